// ==== src/pgp_pkg.sv ====
package pgp_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
    localparam int unsigned TICK_TIME_US = 1000;
    localparam int unsigned TICK_CYCLES  =
        CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;

    // Debounce delays in milliseconds.
    localparam int unsigned DLY_CODE0_MS = 320;
    localparam int unsigned DLY_CODE5_MS = 200;
    localparam int unsigned DLY_LONG_MS  = 600;
    localparam int unsigned DLY_NONE_MS  = 0;
    localparam int unsigned MS_W         = 10;

    // ****************************************************************
    // Register bus and map
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] ADDR_CFG    = 8'h2D;
    localparam logic [7:0] ADDR_IGNORE = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h31;

    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] IGNORE_RESET = 8'h00;

    // Configuration field positions.
    localparam int unsigned CFG_DBNC_MSB     = 7;
    localparam int unsigned CFG_DBNC_LSB     = 4;
    localparam int unsigned CFG_PG2_IGN_BIT  = 3;
    localparam int unsigned CFG_FLAG_POL_BIT = 2;
    localparam int unsigned CFG_GATE_POL_BIT = 1;
    localparam int unsigned CFG_POWER_ON_REQUEST_POL_BIT = 0;

    // Debounce codes.
    localparam logic [3:0] DBNC_CODE_320  = 4'h0;
    localparam logic [3:0] DBNC_CODE_200  = 4'h5;
    localparam logic [3:0] DBNC_CODE_NONE = 4'hF;

    // Status field positions.
    localparam int unsigned ST_PG1_BIT   = 0;
    localparam int unsigned ST_PG2_BIT   = 1;
    localparam int unsigned ST_POWER_ON_REQUEST_BIT  = 2;
    localparam int unsigned ST_FLAG_BIT  = 3;
    localparam int unsigned ST_STATE_LSB = 4;
    localparam int unsigned ST_GATE_BIT  = 6;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic supply_ok;
        logic pri_fast_oc_ok;
        logic pri_acc_oc_ok;
        logic sec_acc_oc_ok;
        logic uv_ok;
        logic local_ov_ok;
        logic load_ov_ok;
    } pgp_limits_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pgp_bus_req_s;

    typedef enum logic [1:0] {
        PG_OFF,
        PG_RISE,
        PG_ON,
        PG_FALL
    } pgp_pg_e;

endpackage

// ==== src/pgp_sync.sv ====
module pgp_sync #(
    parameter int unsigned W = 2
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    initial begin
        if (W < 1) begin
            $error("pgp_sync: W must be at least 1.");
        end
    end

    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;

    // A change is taken only once the second and third stages agree.
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    ff1_reg[i]  <= 1'b0;
                    ff2_reg[i]  <= 1'b0;
                    ff3_reg[i]  <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    ff1_reg[i] <= async_in[i];
                    ff2_reg[i] <= ff1_reg[i];
                    ff3_reg[i] <= ff2_reg[i];
                    if (ff2_reg[i] == ff3_reg[i]) begin
                        sync_out[i] <= ff3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// ==== src/pgp_top.sv ====
// The implementer's own choice: the plain strobed port.
module pgp_top
    import pgp_pkg::*;
#(
    parameter int unsigned TICK_CYC = pgp_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Register port
    input  wire pgp_pkg::pgp_bus_req_s bus_req,
    output logic [pgp_pkg::DATA_W-1:0] bus_rdata,
    // Pins from outside
    input  wire logic                 external_fault_flag_input,
    input  wire logic                 power_on_request,
    // Protection logic, same clock
    input  wire pgp_pkg::pgp_limits_s limits_ok,
    input  wire logic                 oring_switch_on,
    // Outputs
    output logic                      power_good_primary,
    output logic                      power_good_secondary,
    output logic                      oring_switch_gate
);

    import pgp_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (TICK_CYC < 1) begin
            $error("pgp_top: TICK_CYC must be at least 1.");
        end
        if ((2 ** MS_W) <= DLY_LONG_MS) begin
            $error("pgp_top: MS_W is too narrow for the longest delay.");
        end
        if ($bits(pgp_limits_s) + 1 != DATA_W) begin
            $error("pgp_top: fault vector must fill one register.");
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    logic [7:0] cfg_reg;
    logic [7:0] ignore_reg;
    logic [7:0] status_w;
    logic [7:0] rdata_next;

    wire sel_cfg    = (bus_req.addr == ADDR_CFG);
    wire sel_ignore = (bus_req.addr == ADDR_IGNORE);
    wire sel_status = (bus_req.addr == ADDR_STATUS);

    wire wr_cfg    = bus_req.wr && sel_cfg;
    wire wr_ignore = bus_req.wr && sel_ignore;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ignore_reg <= IGNORE_RESET;
        end else if (wr_ignore) begin
            ignore_reg <= bus_req.wdata;
        end
    end

    // Unmapped addresses read as zero.
    // Status is read-only; a write to it is dropped.
    assign rdata_next = !bus_req.rd ? 8'h00 :
                        sel_cfg     ? cfg_reg :
                        sel_ignore  ? ignore_reg :
                        sel_status  ? status_w :
                                      8'h00;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= rdata_next;
        end
    end

    // ****************************************************************
    // Configuration fields
    // ****************************************************************
    wire [3:0] dbnc_code = cfg_reg[CFG_DBNC_MSB:CFG_DBNC_LSB];
    wire       pg2_ign   = cfg_reg[CFG_PG2_IGN_BIT];
    wire       flag_pol  = cfg_reg[CFG_FLAG_POL_BIT];
    wire       gate_pol  = cfg_reg[CFG_GATE_POL_BIT];
    wire       power_on_request_pol  = cfg_reg[CFG_POWER_ON_REQUEST_POL_BIT];

    // Other 0xxx codes fall back to the 320 ms setting.
    localparam logic [MS_W-1:0] MS_320 = MS_W'(DLY_CODE0_MS);
    localparam logic [MS_W-1:0] MS_200 = MS_W'(DLY_CODE5_MS);
    localparam logic [MS_W-1:0] MS_600 = MS_W'(DLY_LONG_MS);
    localparam logic [MS_W-1:0] MS_0   = MS_W'(DLY_NONE_MS);

    logic [MS_W-1:0] delay_ms;

    wire code_none = (dbnc_code == DBNC_CODE_NONE);
    wire code_320  = (dbnc_code == DBNC_CODE_320);
    wire code_200  = (dbnc_code == DBNC_CODE_200);
    wire code_long = dbnc_code[3];

    assign delay_ms = code_none ? MS_0   :
                      code_320  ? MS_320 :
                      code_200  ? MS_200 :
                      code_long ? MS_600 :
                                  MS_320;

    // ****************************************************************
    // Pin inputs
    // ****************************************************************
    // Polarity 1 means low is on; 0 means high is on. The sense is
    // applied ahead of the synchroniser, so a host that flips its pin
    // along with the sense bit causes no false request or fault.
    wire flag_in = external_fault_flag_input ^ flag_pol;
    wire power_on_request_in = power_on_request ^ power_on_request_pol;

    logic [1:0] pins_sync;

    pgp_sync #(
        .W (2)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .async_in ({flag_in, power_on_request_in}),
        .sync_out (pins_sync)
    );

    wire flag_on = pins_sync[1];
    wire power_on_request_on = pins_sync[0];

    wire all_ok = &limits_ok;

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    // The prescaler restarts with each debounce so a delay is never
    // cut short by a partial first millisecond.
    localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

    logic [TICK_W-1:0] tick_cnt_reg;
    logic [MS_W-1:0]   ms_cnt_reg;
    logic              restart;

    wire tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= '0;
        end else if (restart || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ms_cnt_reg <= '0;
        end else if (restart) begin
            ms_cnt_reg <= '0;
        end else if (tick && ms_cnt_reg != {MS_W{1'b1}}) begin
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end
    end

    // The millisecond count stops at all ones so a long hold never wraps.
    wire dbnc_done = (ms_cnt_reg >= delay_ms);

    // ****************************************************************
    // Primary power-good sequencer
    // ****************************************************************
    pgp_pg_e state_reg;
    pgp_pg_e state_next;

    always_comb begin
        state_next = state_reg;
        restart    = 1'b0;
        case (state_reg)
            PG_OFF: begin
                if (power_on_request_on && all_ok) begin
                    state_next = PG_RISE;
                    restart    = 1'b1;
                end
            end
            PG_RISE: begin
                if (!power_on_request_on || !all_ok) begin
                    state_next = PG_OFF;
                end else if (dbnc_done) begin
                    state_next = PG_ON;
                end
            end
            PG_ON: begin
                if (!all_ok) begin
                    state_next = PG_OFF;
                end else if (!power_on_request_on) begin
                    state_next = PG_FALL;
                    restart    = 1'b1;
                end
            end
            PG_FALL: begin
                if (!all_ok) begin
                    state_next = PG_OFF;
                end else if (power_on_request_on) begin
                    state_next = PG_ON;
                end else if (dbnc_done) begin
                    state_next = PG_OFF;
                end
            end
            default: begin
                state_next = PG_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= PG_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    wire pg1_next = (state_next == PG_ON) || (state_next == PG_FALL);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            power_good_primary <= 1'b0;
        end else begin
            power_good_primary <= pg1_next;
        end
    end

    // ****************************************************************
    // Fault mask
    // ****************************************************************
    // Each flag is a fault; an ignored external flag drops the output only
    // when the configuration bit allows it; a lost limit always drops it via primary good.
    wire [7:0] fault_vec = {flag_on, ~limits_ok};
    wire [7:0] fault_use;

    genvar fi;
    generate
        for (fi = 0; fi < 8; fi = fi + 1) begin : g_fault
            assign fault_use[fi] = fault_vec[fi] &&
                                   (pg2_ign || !ignore_reg[fi]);
        end
    endgenerate

    // ****************************************************************
    // Secondary power-good
    // ****************************************************************
    wire       pg2_next  = pg1_next && !(|fault_use);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            power_good_secondary <= 1'b0;
        end else begin
            power_good_secondary <= pg2_next;
        end
    end

    // ****************************************************************
    // OR-ing switch gate
    // ****************************************************************
    // The gate is driven low at reset whichever polarity is chosen later;
    // a low-active switch sees a low level, and so on, until the first edge.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            oring_switch_gate <= 1'b0;
        end else begin
            oring_switch_gate <= oring_switch_on ^ gate_pol;
        end
    end

    // ****************************************************************
    // Status
    // ****************************************************************
    always_comb begin
        status_w                         = 8'h00;
        status_w[ST_PG1_BIT]             = power_good_primary;
        status_w[ST_PG2_BIT]             = power_good_secondary;
        status_w[ST_POWER_ON_REQUEST_BIT]            = power_on_request_on;
        status_w[ST_FLAG_BIT]            = flag_on;
        status_w[ST_STATE_LSB +: 2]      = 2'(state_reg);
        status_w[ST_GATE_BIT]            = oring_switch_gate;
    end

endmodule

// ==== test/pgp_chk.sv ====
module pgp_chk
    import pgp_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4
) (
    // Clock and reset
    input wire logic                         mclk,
    input wire logic                         resetn,
    // Register port
    input wire pgp_pkg::pgp_bus_req_s        bus_req,
    input wire logic [pgp_pkg::DATA_W-1:0]   bus_rdata,
    // Pins and limits
    input wire logic                         power_on_request,
    input wire pgp_pkg::pgp_limits_s         limits_ok,
    input wire logic                         oring_switch_on,
    // Outputs
    input wire logic                         power_good_primary,
    input wire logic                         oring_switch_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Mirror of the configuration and run-length counters
    // ****************************************************************
    logic [7:0]  cfg_q;
    int unsigned on_cnt;
    int unsigned off_cnt;
    wire         req_act = power_on_request ^ cfg_q[0];
    wire         all_ok  = &limits_ok;
    wire         rd_cfg  = bus_req.rd && bus_req.addr == ADDR_CFG;
    wire         mapped  = bus_req.addr inside {ADDR_CFG, ADDR_IGNORE,
                                                ADDR_STATUS};
    wire [3:0]   code    = cfg_q[7:4];
    int unsigned dly_cyc;

    // Debounce length in cycles for the code now configured.
    assign dly_cyc = (code == DBNC_CODE_NONE) ? 0 :
                     (code == DBNC_CODE_200)  ? DLY_CODE5_MS * TICK_CYC :
                     code[3]                  ? DLY_LONG_MS * TICK_CYC :
                                                DLY_CODE0_MS * TICK_CYC;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_q   <= CFG_RESET;
            on_cnt  <= 0;
            off_cnt <= 0;
        end else begin
            if (bus_req.wr && bus_req.addr == ADDR_CFG) begin
                cfg_q <= bus_req.wdata;
            end
            on_cnt  <= (req_act && all_ok) ? on_cnt + 1 : 0;
            off_cnt <= req_act ? 0 : off_cnt + 1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_gate_pol: assert property (1'b1 |=> oring_switch_gate ==
        ($past(oring_switch_on) ^ $past(cfg_q[1])))
        else $error("gate level wrong");
    a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data outside read slot");
    a_read_cfg: assert property (rd_cfg |=> bus_rdata == $past(cfg_q))
        else $error("config readback wrong");
    a_unmapped_zero: assert property (bus_req.rd && !mapped
        |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_limit_drop: assert property (!all_ok |=> !power_good_primary)
        else $error("primary good with limit lost");
    a_rise_dbnc: assert property ($rose(power_good_primary)
        && code != DBNC_CODE_NONE |-> on_cnt > dly_cyc)
        else $error("primary good rose early");
    a_fall_dbnc: assert property ($fell(power_good_primary) &&
        $past(all_ok) && code != DBNC_CODE_NONE |-> off_cnt > dly_cyc)
        else $error("primary good fell early");
    a_quick_on: assert property (on_cnt == 12 &&
        cfg_q[7:4] == 4'hF |-> power_good_primary)
        else $error("no-delay code did not raise primary good");
endmodule

bind pgp_top pgp_chk #(.TICK_CYC(TICK_CYC)) i_chk (
    .mclk               (mclk),
    .resetn             (resetn),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .power_on_request   (power_on_request),
    .limits_ok          (limits_ok),
    .oring_switch_on    (oring_switch_on),
    .power_good_primary (power_good_primary),
    .oring_switch_gate  (oring_switch_gate)
);

// ==== test/pgp_host.sv ====
module pgp_host (
    // Commands from the bench
    input wire logic       req_on,
    input wire logic       flag_on,
    input wire logic [7:0] cfg,
    // Pins toward the controller
    output logic           power_on_request,
    output logic           external_fault_flag_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Pin levels
    // ****************************************************************
    // An inverted pin rests high, so its off level is the inverse.
    assign power_on_request          = req_on ^ cfg[0];
    assign external_fault_flag_input = flag_on ^ cfg[2];
endmodule

// ==== test/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pgp_pkg::*;
    // ****************************************************************
    // Stimulus, model and checks
    // ****************************************************************
    localparam int TK = 4;
    logic         mclk      = 1'b0;
    logic         resetn    = 1'b0;
    pgp_bus_req_s bus_req   = '0;
    pgp_limits_s  limits_ok = '1;
    logic         sw_on     = 1'b0;
    logic         req_on    = 1'b0;
    logic         flag_on   = 1'b0;
    logic [7:0]   cfg_m     = 8'h00;
    logic [7:0]   bus_rdata;
    logic         flag_pin;
    logic         req_pin;
    logic         pg1;
    logic         pg2;
    logic         gate;
    int           n_errors  = 0;
    int           checked   = 0;
    int           codes[$]  = '{0, 5, 8, 15};

    pgp_top #(.TICK_CYC(TK)) i_dut (
        .mclk(mclk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .external_fault_flag_input(flag_pin),
        .power_on_request(req_pin), .limits_ok(limits_ok),
        .oring_switch_on(sw_on), .power_good_primary(pg1),
        .power_good_secondary(pg2), .oring_switch_gate(gate));
    pgp_host i_host (.req_on(req_on), .flag_on(flag_on), .cfg(cfg_m),
        .power_on_request(req_pin), .external_fault_flag_input(flag_pin));

    initial forever #20 mclk = ~mclk;

    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        if (a == ADDR_CFG) cfg_m <= d;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk("rdata", exp, bus_rdata);
    endtask
    function automatic int dms(int c);
        if (c == 15) return 0;
        if (c == 5) return 200;
        return (c >= 8) ? 600 : 320;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        int         d;
        logic [7:0] r;
        r = $urandom(93697);
        wt(5);
        @(posedge mclk) resetn <= 1'b1;
        rd(ADDR_CFG, 8'h00);
        rd(ADDR_IGNORE, 8'h00);
        // The request sense stays fixed here so no pulse reaches good.
        repeat (6) begin
            r = $urandom;
            wr(ADDR_CFG, r & 8'hFE);
            wr(ADDR_IGNORE, ~r);
            wr(8'h2E, r);
            rd(ADDR_CFG, r & 8'hFE);
            rd(ADDR_IGNORE, ~r);
            rd(8'h2E, 8'h00);
        end
        wr(ADDR_CFG, 8'hF0);
        wr(ADDR_IGNORE, 8'h00);
        $display("test registers done");
        foreach (codes[i]) begin
            r = $urandom;
            wr(ADDR_CFG, {codes[i][3:0], 1'b0, r[2:0]});
            @(posedge mclk) sw_on <= r[5];
            wt(20);
            chk("gate", 8'(r[5] ^ r[1]), 8'(gate));
            d = dms(codes[i]) * TK;
            @(posedge mclk) req_on <= 1'b1;
            wt(d + 5);
            chk("pg1 early", 8'h00, 8'(pg1));
            wt(30);
            chk("pg1 on", 8'h01, 8'(pg1));
            chk("pg2 on", 8'h01, 8'(pg2));
            @(posedge mclk) req_on <= 1'b0;
            wt(d + 5);
            chk("pg1 hold", 8'h01, 8'(pg1));
            wt(30);
            chk("pg1 off", 8'h00, 8'(pg1));
        end
        $display("test debounce done");
        wr(ADDR_CFG, 8'hF0);
        @(posedge mclk) req_on <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wt(20);
            chk("pg1 up", 8'h01, 8'(pg1));
            @(posedge mclk) limits_ok <= ~(7'h01 << i);
            wt(2);
            chk("pg1 lost", 8'h00, 8'(pg1));
            @(posedge mclk) limits_ok <= '1;
        end
        $display("test limits done");
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_IGNORE, 8'h80);
            wr(ADDR_CFG, {5'h1E, k[0], 2'b00});
            @(posedge mclk) flag_on <= 1'b1;
            wt(12);
            chk("pg2 masked", 8'h01, 8'(pg2));
            wr(ADDR_CFG, {5'h1F, k[0], 2'b00});
            wt(12);
            chk("pg2 ignored", 8'h00, 8'(pg2));
            wr(ADDR_IGNORE, 8'h00);
            wr(ADDR_CFG, {5'h1E, k[0], 2'b00});
            wt(12);
            chk("pg2 flag", 8'h00, 8'(pg2));
            @(posedge mclk) flag_on <= 1'b0;
            wt(12);
            chk("pg2 back", 8'h01, 8'(pg2));
        end
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, {1'b0, sw_on, 6'h27});
        $display("test flags done");
        conclude();
    end

    // The full run needs about 9700 cycles.
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        conclude();
    end
endmodule
